/* rtl/usbac_pkg.sv */
// Constants and types of the USB audio codec sequencer.
// Assumes one 100 MHz system clock and a plain register port from the USB core.
package usbac_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_TIME_US = 700;
	localparam int POR_CYC = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUSP_TIME_MS = 5;
	localparam int SUSP_CYC = (SUSP_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int FS_HZ = 48000;
	localparam int MOD_OSR = 64;
	localparam int INTERP_OSR = 8;
	localparam int DIV64 = CLK_HZ / (MOD_OSR * FS_HZ);
	localparam int PB_DEPTH = 64;
	localparam int REC_DEPTH = 64;
	localparam logic [15:0] MIDSCALE = 16'h0000;
	localparam logic signed [7:0] REC_GAIN_MAX = 8'sh1E;
	localparam logic signed [7:0] REC_GAIN_MIN = -8'sh0C;
	localparam logic [7:0] ATT_MAX = 8'h4C;
	// Register offsets
	localparam logic [3:0] OFS_REC_GAIN = 4'h0;
	localparam logic [3:0] OFS_SIDE_ATT = 4'h1;
	localparam logic [3:0] OFS_OUT_ATT_L = 4'h2;
	localparam logic [3:0] OFS_OUT_ATT_R = 4'h3;
	localparam logic [3:0] OFS_MUTES = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;
	// Mute register fields
	localparam int MUTE_REC_BIT = 0;
	localparam int MUTE_SIDE_BIT = 1;
	localparam int MUTE_OUT_BIT = 2;
	// Reset values of settings
	localparam logic signed [7:0] REC_GAIN_RST = 8'sh00;
	localparam logic [7:0] ATT_RST = 8'h00;
	localparam logic [2:0] MUTES_RST = 3'h0;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} usbac_bus_req_t;

	typedef struct packed {
		logic signed [7:0] rec_gain;
		logic [7:0] side_att;
		logic [7:0] out_att_l;
		logic [7:0] out_att_r;
		logic rec_mute;
		logic side_mute;
		logic out_mute;
	} usbac_gain_t;

	typedef enum logic [3:0] {
		PB_IDLE = 4'h1,
		PB_FILL = 4'h2,
		PB_PLAY = 4'h4,
		PB_DRAIN = 4'h8
	} usbac_pb_state_t;
endpackage : usbac_pkg

/* rtl/usbac_seq.sv */
// Sequencer of the USB audio codec: reset release, playback and record control, suspend.
// Assumes a USB core that decodes tokens and requests into the strobes below, all synchronous.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module usbac_seq #(
	parameter int POR_CYCLES = usbac_pkg::POR_CYC,
	parameter int SUSP_CYCLES = usbac_pkg::SUSP_CYC,
	parameter int DIV_64FS = usbac_pkg::DIV64,
	parameter int PB_DEPTH = usbac_pkg::PB_DEPTH,
	parameter int REC_DEPTH = usbac_pkg::REC_DEPTH
) (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_B_IN,
	// Supply and bus state
	input wire logic VBUS_OK_IN,
	input wire logic BUS_ATTACH_IN,
	input wire logic BUS_IDLE_IN,
	input wire logic SOF_IN,
	// Playback stream
	input wire logic PB_ALT_IN,
	input wire logic PB_VALID_IN,
	input wire logic [31:0] PB_DATA_IN,
	input wire logic PB_PKT_END_IN,
	// Record stream
	input wire logic REC_ALT_IN,
	input wire logic MIC_BIT_IN,
	input wire logic REC_RD_IN,
	output logic [15:0] REC_DATA_OUT,
	output logic REC_VALID_OUT,
	// Microphone pins
	input wire logic MIC_PREAMP_SELECT_IN,
	input wire logic MIC_INPUT_SILENCE_CONTROL_IN,
	output logic MIC_PREAMP_SELECT_OUT,
	output logic MIC_INPUT_SILENCE_CONTROL_OUT,
	// Register port
	input wire usbac_pkg::usbac_bus_req_t BUS_REQ_IN,
	output logic [15:0] RD_DATA_OUT,
	// Analog control and data
	output usbac_pkg::usbac_gain_t GAIN_OUT,
	output logic [15:0] DAC_L_OUT,
	output logic [15:0] DAC_R_OUT,
	output logic MOD_EN_OUT,
	output logic HP_CONNECT_OUT,
	// Status
	output logic SETUP_READY_OUT,
	output logic SUSPEND_INDICATOR_OUT,
	output logic PB_FLAG_OUT,
	output logic REC_FLAG_OUT
);
	import usbac_pkg::*;

	localparam int POR_W = $clog2(POR_CYCLES + 1);
	localparam int SUSP_W = $clog2(SUSP_CYCLES + 1);
	localparam int DIV_W = $clog2(DIV_64FS + 1);
	localparam int PB_AW = $clog2(PB_DEPTH);
	localparam int REC_AW = $clog2(REC_DEPTH);

	logic [POR_W-1:0] por_cnt_r;
	logic por_done_r;
	logic ready;
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			por_cnt_r <= '0;
			por_done_r <= 1'b0;
		end else if (!VBUS_OK_IN) begin
			por_cnt_r <= '0;
			por_done_r <= 1'b0;
		end else if (por_cnt_r == POR_W'(POR_CYCLES - 1)) begin
			por_done_r <= 1'b1;
		end else begin
			por_cnt_r <= por_cnt_r + 1'b1;
		end
	end
	// setup gated by reset and attach
	assign ready = por_done_r && BUS_ATTACH_IN;

	// all rates derive from one clock
	logic [DIV_W-1:0] div_r;
	logic [2:0] sub8_r;
	logic [2:0] sub64_r;
	logic en64;
	logic en8;
	logic enfs;
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			div_r <= '0;
			sub8_r <= 3'h0;
			sub64_r <= 3'h0;
		end else if (en64) begin
			div_r <= '0;
			sub8_r <= sub8_r + 3'h1;
			if (sub8_r == 3'h7) begin
				sub64_r <= sub64_r + 3'h1;
			end
		end else begin
			div_r <= div_r + 1'b1;
		end
	end
	assign en64 = (div_r == DIV_W'(DIV_64FS - 1));
	assign en8 = en64 && (sub8_r == 3'h7);
	assign enfs = en8 && (sub64_r == 3'h7);

	logic [SUSP_W-1:0] idle_cnt_r;
	logic susp_r;
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			idle_cnt_r <= '0;
			susp_r <= 1'b0;
		end else if (!BUS_IDLE_IN || !ready) begin
			idle_cnt_r <= '0;
			susp_r <= 1'b0;
		end else if (idle_cnt_r == SUSP_W'(SUSP_CYCLES - 1)) begin
			susp_r <= 1'b1;
		end else begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

	// Settings registers
	usbac_gain_t gain_r;
	logic signed [7:0] wgain;
	logic [7:0] watt;
	assign wgain = signed'(BUS_REQ_IN.wdata[7:0]);
	assign watt = (BUS_REQ_IN.wdata[7:0] > ATT_MAX) ? ATT_MAX : BUS_REQ_IN.wdata[7:0];
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			gain_r.rec_gain <= REC_GAIN_RST;
			gain_r.side_att <= ATT_RST;
			gain_r.out_att_l <= ATT_RST;
			gain_r.out_att_r <= ATT_RST;
			{gain_r.out_mute, gain_r.side_mute, gain_r.rec_mute} <= MUTES_RST;
		end else if (BUS_REQ_IN.wr && ready) begin
			if (BUS_REQ_IN.addr == OFS_REC_GAIN) begin
				if (wgain > REC_GAIN_MAX) begin
					gain_r.rec_gain <= REC_GAIN_MAX;
				end else if (wgain < REC_GAIN_MIN) begin
					gain_r.rec_gain <= REC_GAIN_MIN;
				end else begin
					gain_r.rec_gain <= wgain;
				end
			end else if (BUS_REQ_IN.addr == OFS_SIDE_ATT) begin
				gain_r.side_att <= watt;
			end else if (BUS_REQ_IN.addr == OFS_OUT_ATT_L) begin
				gain_r.out_att_l <= watt;
			end else if (BUS_REQ_IN.addr == OFS_OUT_ATT_R) begin
				gain_r.out_att_r <= watt;
			end else if (BUS_REQ_IN.addr == OFS_MUTES) begin
				gain_r.rec_mute <= BUS_REQ_IN.wdata[MUTE_REC_BIT];
				gain_r.side_mute <= BUS_REQ_IN.wdata[MUTE_SIDE_BIT];
				gain_r.out_mute <= BUS_REQ_IN.wdata[MUTE_OUT_BIT];
			end
		end
	end
	assign GAIN_OUT = gain_r;

	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			MIC_PREAMP_SELECT_OUT <= 1'b0;
			MIC_INPUT_SILENCE_CONTROL_OUT <= 1'b1;
		end else begin
			MIC_PREAMP_SELECT_OUT <= MIC_PREAMP_SELECT_IN;
			MIC_INPUT_SILENCE_CONTROL_OUT <= MIC_INPUT_SILENCE_CONTROL_IN;
		end
	end

	// Playback buffer and sequencer
	logic [31:0] pb_mem [PB_DEPTH];
	logic [PB_AW:0] pb_wp_r;
	logic [PB_AW:0] pb_rp_r;
	logic pb_empty;
	logic pb_full;
	logic pb_wr;
	logic pb_rd;
	usbac_pb_state_t pb_st_r;
	usbac_pb_state_t pb_st_nxt;
	assign pb_empty = (pb_wp_r == pb_rp_r);
	assign pb_full = (pb_wp_r[PB_AW-1:0] == pb_rp_r[PB_AW-1:0]) && (pb_wp_r[PB_AW] != pb_rp_r[PB_AW]);
	// Overflow drops new samples; the host clock adapts before it matters
	assign pb_wr = PB_VALID_IN && ready && PB_ALT_IN && !pb_full && !susp_r;
	assign pb_rd = enfs && !pb_empty && (pb_st_r == PB_PLAY || pb_st_r == PB_DRAIN);
	always_ff @(posedge SYS_CLK_IN) begin
		if (pb_wr) begin
			pb_mem[pb_wp_r[PB_AW-1:0]] <= PB_DATA_IN;
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pb_wp_r <= '0;
			pb_rp_r <= '0;
		end else if (pb_st_r == PB_IDLE && pb_st_nxt == PB_IDLE) begin
			pb_wp_r <= '0;
			pb_rp_r <= '0;
		end else begin
			pb_wp_r <= pb_wp_r + (PB_AW + 1)'(pb_wr);
			pb_rp_r <= pb_rp_r + (PB_AW + 1)'(pb_rd);
		end
	end
	logic pkt_seen_r;
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pkt_seen_r <= 1'b0;
		end else if (pb_st_r != PB_FILL) begin
			pkt_seen_r <= 1'b0;
		end else if (PB_PKT_END_IN) begin
			pkt_seen_r <= 1'b1;
		end
	end
	always_comb begin
		pb_st_nxt = pb_st_r;
		case (pb_st_r)
			PB_IDLE: begin
				if (pb_wr) begin
					pb_st_nxt = PB_FILL;
				end
			end
			PB_FILL: begin
				// start on SOF after first packet
				if (!PB_ALT_IN) begin
					pb_st_nxt = PB_DRAIN;
				end else if (pkt_seen_r && SOF_IN) begin
					pb_st_nxt = PB_PLAY;
				end
			end
			PB_PLAY: begin
				if (!PB_ALT_IN || susp_r) begin
					pb_st_nxt = PB_DRAIN;
				end
			end
			PB_DRAIN: begin
				if (pb_empty) begin
					pb_st_nxt = PB_IDLE;
				end
			end
			default: pb_st_nxt = PB_IDLE;
		endcase
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pb_st_r <= PB_IDLE;
		end else begin
			pb_st_r <= pb_st_nxt;
		end
	end

	// 8x linear interpolation, 64x modulator enable
	logic signed [16:0] step_l_r;
	logic signed [16:0] step_r_r;
	logic signed [16:0] acc_l_r;
	logic signed [16:0] acc_r_r;
	logic signed [16:0] tgt_l;
	logic signed [16:0] tgt_r;
	logic playing;
	assign playing = (pb_st_r == PB_PLAY || pb_st_r == PB_DRAIN);
	assign tgt_l = pb_rd ? 17'(signed'(pb_mem[pb_rp_r[PB_AW-1:0]][31:16])) : 17'(signed'(MIDSCALE));
	assign tgt_r = pb_rd ? 17'(signed'(pb_mem[pb_rp_r[PB_AW-1:0]][15:0])) : 17'(signed'(MIDSCALE));
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			step_l_r <= '0;
			step_r_r <= '0;
			acc_l_r <= '0;
			acc_r_r <= '0;
		end else if (!playing) begin
			step_l_r <= '0;
			step_r_r <= '0;
			acc_l_r <= 17'(signed'(MIDSCALE));
			acc_r_r <= 17'(signed'(MIDSCALE));
		end else if (enfs) begin
			step_l_r <= (tgt_l - acc_l_r) >>> 3;
			step_r_r <= (tgt_r - acc_r_r) >>> 3;
		end else if (en8) begin
			acc_l_r <= acc_l_r + step_l_r;
			acc_r_r <= acc_r_r + step_r_r;
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			DAC_L_OUT <= MIDSCALE;
			DAC_R_OUT <= MIDSCALE;
			MOD_EN_OUT <= 1'b0;
		end else begin
			DAC_L_OUT <= playing ? acc_l_r[15:0] : MIDSCALE;
			DAC_R_OUT <= playing ? acc_r_r[15:0] : MIDSCALE;
			MOD_EN_OUT <= en64;
		end
	end

	// 64-to-1 decimation by counting modulator ones
	logic [6:0] ones_r;
	logic [6:0] ones_tot;
	logic [15:0] dec_sample;
	logic rec_on;
	assign rec_on = REC_ALT_IN && ready && !susp_r;
	assign ones_tot = ones_r + 7'(MIC_BIT_IN);
	assign dec_sample = (ones_tot == 7'h40) ? 16'h7FFF : {~ones_tot[5], ones_tot[4:0], 10'h000};
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ones_r <= 7'h00;
		end else if (enfs) begin
			ones_r <= 7'h00;
		end else if (en64) begin
			ones_r <= ones_tot;
		end
	end

	// record buffer fills while interface selected
	logic [15:0] rec_mem [REC_DEPTH];
	logic [REC_AW:0] rec_wp_r;
	logic [REC_AW:0] rec_rp_r;
	logic rec_wr;
	logic rec_rd;
	logic rec_full;
	assign rec_full = (rec_wp_r[REC_AW-1:0] == rec_rp_r[REC_AW-1:0]) && (rec_wp_r[REC_AW] != rec_rp_r[REC_AW]);
	assign rec_wr = rec_on && enfs && !rec_full;
	assign rec_rd = REC_RD_IN && (rec_wp_r != rec_rp_r);
	always_ff @(posedge SYS_CLK_IN) begin
		if (rec_wr) begin
			rec_mem[rec_wp_r[REC_AW-1:0]] <= gain_r.rec_mute ? MIDSCALE : dec_sample;
		end
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rec_wp_r <= '0;
			rec_rp_r <= '0;
			REC_DATA_OUT <= MIDSCALE;
			REC_VALID_OUT <= 1'b0;
		end else if (!rec_on) begin
			rec_wp_r <= '0;
			rec_rp_r <= '0;
			REC_VALID_OUT <= 1'b0;
		end else begin
			rec_wp_r <= rec_wp_r + (REC_AW + 1)'(rec_wr);
			rec_rp_r <= rec_rp_r + (REC_AW + 1)'(rec_rd);
			REC_VALID_OUT <= rec_rd;
			if (rec_rd) begin
				REC_DATA_OUT <= rec_mem[rec_rp_r[REC_AW-1:0]];
			end
		end
	end

	// Status outputs and read port
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			SETUP_READY_OUT <= 1'b0;
			SUSPEND_INDICATOR_OUT <= 1'b0;
			HP_CONNECT_OUT <= 1'b0;
			PB_FLAG_OUT <= 1'b0;
			REC_FLAG_OUT <= 1'b0;
			RD_DATA_OUT <= 16'h0000;
		end else begin
			SETUP_READY_OUT <= ready;
			SUSPEND_INDICATOR_OUT <= susp_r;
			HP_CONNECT_OUT <= ready && !susp_r;
			PB_FLAG_OUT <= playing;
			REC_FLAG_OUT <= rec_on;
			RD_DATA_OUT <= 16'h0000;
			if (BUS_REQ_IN.rd) begin
				if (BUS_REQ_IN.addr == OFS_REC_GAIN) begin
					RD_DATA_OUT <= 16'(gain_r.rec_gain);
				end else if (BUS_REQ_IN.addr == OFS_SIDE_ATT) begin
					RD_DATA_OUT <= {8'h00, gain_r.side_att};
				end else if (BUS_REQ_IN.addr == OFS_OUT_ATT_L) begin
					RD_DATA_OUT <= {8'h00, gain_r.out_att_l};
				end else if (BUS_REQ_IN.addr == OFS_OUT_ATT_R) begin
					RD_DATA_OUT <= {8'h00, gain_r.out_att_r};
				end else if (BUS_REQ_IN.addr == OFS_MUTES) begin
					RD_DATA_OUT <= {13'h0000, gain_r.out_mute, gain_r.side_mute, gain_r.rec_mute};
				end else if (BUS_REQ_IN.addr == OFS_STATUS) begin
					RD_DATA_OUT <= {8'h00, pb_st_r, rec_on, susp_r, ready, por_done_r};
				end
			end
		end
	end

	// Assertions
	sequence s_pkt_then_sof;
		pkt_seen_r && SOF_IN && PB_ALT_IN;
	endsequence
	a_sof_start_play: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		((pb_st_r == PB_FILL) and s_pkt_then_sof) |=> (pb_st_r == PB_PLAY))
		else $error("Playback did not start on SOF");
	a_no_early_play: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		(pb_st_r == PB_FILL) && !SOF_IN |=> (pb_st_r != PB_PLAY))
		else $error("Playback started without SOF");
	a_drain_to_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		(pb_st_r == PB_DRAIN) && !pb_empty |=> (pb_st_r == PB_DRAIN))
		else $error("Drain ended with samples left");
	a_idle_midscale: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		(pb_st_r == PB_IDLE) ##1 (pb_st_r == PB_IDLE) |-> (DAC_L_OUT == MIDSCALE) && (DAC_R_OUT == MIDSCALE))
		else $error("Idle output not midscale");
	a_wake_fast: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		susp_r && !BUS_IDLE_IN |=> !susp_r ##1 !SUSPEND_INDICATOR_OUT)
		else $error("Suspend not left on bus activity");
	a_suspend_hp: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		SUSPEND_INDICATOR_OUT |-> !HP_CONNECT_OUT)
		else $error("Headphone connected in suspend");
	a_suspend_time: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		$rose(susp_r) |-> (idle_cnt_r == SUSP_W'(SUSP_CYCLES - 1)) && $past(BUS_IDLE_IN))
		else $error("Suspend entered before idle time");
	a_por_wait: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		$rose(por_done_r) |-> (por_cnt_r == POR_W'(POR_CYCLES - 1)))
		else $error("Reset released early");
	a_gain_range: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		(gain_r.rec_gain <= REC_GAIN_MAX) && (gain_r.rec_gain >= REC_GAIN_MIN) && (gain_r.out_att_l <= ATT_MAX))
		else $error("Setting outside range");
	a_flag_play: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		playing |=> PB_FLAG_OUT)
		else $error("Playback flag missing");
	a_setup_gate: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
		!ready && BUS_REQ_IN.wr |=> $stable(gain_r))
		else $error("Write taken before ready");
endmodule : usbac_seq

/* sim/usbac_host_model.sv */
// Host-side model: bus state, frame markers, alt settings and playback packets.
// Assumes the testbench calls its tasks; every change follows a rising clock edge.
`timescale 1ns/1ps
module usbac_host_model (
	// Clock
	input wire logic clk_in,
	// Bus and streams toward the device
	output logic attach_out,
	output logic idle_out,
	output logic sof_out,
	output logic pb_alt_out,
	output logic pb_valid_out,
	output logic [31:0] pb_data_out,
	output logic pb_end_out,
	output logic rec_alt_out
);
	initial begin
		attach_out = 1'b1;
		idle_out = 1'b0;
		sof_out = 1'b0;
		pb_alt_out = 1'b0;
		pb_valid_out = 1'b0;
		pb_data_out = 32'h5A5A_A5A5;
		pb_end_out = 1'b0;
		rec_alt_out = 1'b0;
	end

	task automatic set_lvl(input logic pb, input logic rec, input logic idle);
		@(posedge clk_in);
		pb_alt_out <= pb;
		rec_alt_out <= rec;
		idle_out <= idle;
	endtask : set_lvl

	task automatic send_pkt(input int n, input logic [31:0] first);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			pb_valid_out <= 1'b1;
			pb_data_out <= first + 32'(i);
		end
		@(posedge clk_in);
		pb_valid_out <= 1'b0;
		// Released data toggles so a stale sample is never mistaken for a fresh one
		pb_data_out <= ~pb_data_out;
		pb_end_out <= 1'b1;
		@(posedge clk_in);
		pb_end_out <= 1'b0;
	endtask : send_pkt

	task automatic send_sof;
		@(posedge clk_in);
		sof_out <= 1'b1;
		@(posedge clk_in);
		sof_out <= 1'b0;
	endtask : send_sof
endmodule : usbac_host_model

/* sim/usbac_seq_tb.sv */
// Self-checking bench of the sequencer: register port, playback, record, suspend.
// Assumes shortened reset, suspend and rate counts; host side comes from the model.
`timescale 1ns/1ps
module usbac_seq_tb;
	import usbac_pkg::*;
	localparam int POR = 20;
	localparam int SUSP = 50;
	localparam int DIV = 2;
	logic clk, rst_b, vbus, mic_bit, rec_rd, amp_pin, sil_pin;
	logic attach, idle, sof, pb_alt, pb_valid, pb_end, rec_alt;
	logic [31:0] pb_data;
	logic [15:0] rec_data, rd_data, dac_l, dac_r, d;
	logic rec_valid, amp_out, sil_out, mod_en, hp, ready, susp, pb_flag, rec_flag;
	usbac_bus_req_t req;
	usbac_gain_t gain;
	int err_count, compares, n;
	logic [3:0] ofs [7];
	logic [15:0] val [7];
	logic [15:0] exp_v [7];

	usbac_host_model usbac_host_model_i (.clk_in(clk), .attach_out(attach), .idle_out(idle), .sof_out(sof),
		.pb_alt_out(pb_alt), .pb_valid_out(pb_valid), .pb_data_out(pb_data), .pb_end_out(pb_end),
		.rec_alt_out(rec_alt));

	usbac_seq #(.POR_CYCLES(POR), .SUSP_CYCLES(SUSP), .DIV_64FS(DIV), .PB_DEPTH(64), .REC_DEPTH(64)) usbac_seq_i (
		.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .VBUS_OK_IN(vbus), .BUS_ATTACH_IN(attach), .BUS_IDLE_IN(idle),
		.SOF_IN(sof), .PB_ALT_IN(pb_alt), .PB_VALID_IN(pb_valid), .PB_DATA_IN(pb_data), .PB_PKT_END_IN(pb_end),
		.REC_ALT_IN(rec_alt), .MIC_BIT_IN(mic_bit), .REC_RD_IN(rec_rd), .REC_DATA_OUT(rec_data),
		.REC_VALID_OUT(rec_valid), .MIC_PREAMP_SELECT_IN(amp_pin), .MIC_INPUT_SILENCE_CONTROL_IN(sil_pin),
		.MIC_PREAMP_SELECT_OUT(amp_out), .MIC_INPUT_SILENCE_CONTROL_OUT(sil_out), .BUS_REQ_IN(req),
		.RD_DATA_OUT(rd_data), .GAIN_OUT(gain), .DAC_L_OUT(dac_l), .DAC_R_OUT(dac_r), .MOD_EN_OUT(mod_en),
		.HP_CONNECT_OUT(hp), .SETUP_READY_OUT(ready), .SUSPEND_INDICATOR_OUT(susp), .PB_FLAG_OUT(pb_flag),
		.REC_FLAG_OUT(rec_flag));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc

	// Bounded wait; the caller compares the level afterwards
	task automatic wait_for(ref logic s, input logic v, input int lim, output int c);
		c = 0;
		while (s !== v && c < lim) begin
			cyc(1);
			c++;
		end
	endtask : wait_for

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
		// Let the write settle before the caller looks at the result
		#1;
	endtask : wr

	task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		check(32'(rd_data & m), 32'(e));
	endtask : rchk

	task automatic pop;
		@(posedge clk);
		rec_rd <= 1'b1;
		@(posedge clk);
		rec_rd <= 1'b0;
		#1;
	endtask : pop

	task automatic print_verdict;
		if (err_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end

	initial begin
		rst_b = 1'b0;
		vbus = 1'b1;
		mic_bit = 1'b1;
		rec_rd = 1'b0;
		amp_pin = 1'b0;
		sil_pin = 1'b0;
		req = '0;
		err_count = 0;
		compares = 0;
		ofs = '{OFS_REC_GAIN, OFS_REC_GAIN, OFS_REC_GAIN, OFS_SIDE_ATT, OFS_OUT_ATT_L, OFS_OUT_ATT_R, 4'hF};
		val = '{16'h0028, 16'hFFEC, 16'h001E, 16'h0064, 16'h004C, 16'h0007, 16'h1234};
		exp_v = '{16'h001E, 16'h00F4, 16'h001E, 16'h004C, 16'h004C, 16'h0007, 16'h0000};
		cyc(2);
		check(sil_out, 1'b1);
		check(dac_l, MIDSCALE);
		@(posedge clk);
		rst_b <= 1'b1;
		// A write while the reset delay runs must be dropped
		wr(OFS_REC_GAIN, 16'h0005);
		check(ready, 1'b0);
		wait_for(ready, 1'b1, 40, n);
		check((n + 2 >= POR) && (n + 2 <= POR + 3), 1'b1);
		rchk(OFS_REC_GAIN, 16'h00FF, 16'h0000);
		rchk(OFS_STATUS, 16'h00FF, 16'h0013);
		for (int i = 0; i < 7; i++) begin
			wr(ofs[i], val[i]);
			rchk(ofs[i], 16'h00FF, exp_v[i]);
		end
		check({gain.out_att_l, gain.out_att_r}, 16'h4C07);
		wr(OFS_MUTES, 16'h0007);
		check({gain.rec_mute, gain.side_mute, gain.out_mute}, 3'h7);
		rchk(OFS_MUTES, 16'h0007, 16'h0007);
		@(posedge clk);
		amp_pin <= 1'b1;
		sil_pin <= 1'b1;
		cyc(2);
		check({amp_out, sil_out}, 2'h3);
		@(posedge clk);
		sil_pin <= 1'b0;
		cyc(2);
		check({amp_out, sil_out}, 2'h2);
		wait_for(mod_en, 1'b1, 10, n);
		cyc(1);
		wait_for(mod_en, 1'b1, 10, n);
		check(n + 1, DIV);
		usbac_host_model_i.set_lvl(1'b1, 1'b0, 1'b0);
		usbac_host_model_i.send_pkt(4, 32'h1000_2000);
		cyc(1);
		check({pb_flag, dac_l}, {1'b0, MIDSCALE});
		rchk(OFS_STATUS, 16'h00F0, 16'h0020);
		usbac_host_model_i.send_sof();
		wait_for(pb_flag, 1'b1, 6, n);
		check(pb_flag, 1'b1);
		usbac_host_model_i.set_lvl(1'b0, 1'b0, 1'b0);
		cyc(20);
		check(pb_flag, 1'b1);
		wait_for(pb_flag, 1'b0, 1500, n);
		check(pb_flag, 1'b0);
		cyc(20);
		check({dac_l, dac_r}, {MIDSCALE, MIDSCALE});
		// Record mute off so captured samples reach the buffer
		wr(OFS_MUTES, 16'h0000);
		usbac_host_model_i.set_lvl(1'b0, 1'b1, 1'b0);
		wait_for(rec_flag, 1'b1, 10, n);
		check(rec_flag, 1'b1);
		rchk(OFS_STATUS, 16'h0008, 16'h0008);
		cyc(300);
		pop();
		check(rec_valid, 1'b1);
		check(rec_data, 16'h7FFF);
		usbac_host_model_i.set_lvl(1'b0, 1'b0, 1'b0);
		wait_for(rec_flag, 1'b0, 10, n);
		check(rec_flag, 1'b0);
		pop();
		check(rec_valid, 1'b0);
		check(hp, 1'b1);
		usbac_host_model_i.set_lvl(1'b0, 1'b0, 1'b1);
		cyc(SUSP - 10);
		check(susp, 1'b0);
		wait_for(susp, 1'b1, 20, n);
		check({susp, hp}, 2'h2);
		rchk(OFS_STATUS, 16'h0004, 16'h0004);
		usbac_host_model_i.set_lvl(1'b0, 1'b0, 1'b0);
		cyc(2);
		check(susp, 1'b0);
		print_verdict();
	end
endmodule : usbac_seq_tb
